// File: sgfc_global_ctrl.sv
// global control register bank of the switch: frame drop policy,
// flow control enables, back-off mode and address aging control
// assumes a plain register port on the 50 MHz core clock, link status
// and frame descriptors from core logic, and two asynchronous strap pins
`timescale 1ns/1ps
`default_nettype none
`include "sgfc_consts.svh"

// How it works
// - drop select set drops 8808 or DA
// - drop select clear drops pause frames only
// - link loss starts one short fast pass
// - link loss ages out every learned address
// - pass-all forwards every frame, even bad
// - long frames accepted only with enable set
// - tx pause follows negotiation unless disabled
// - rx pause follows negotiation unless disabled
// - one strap sets both pause disable defaults
// - length check drops mismatched short length
// - aging runs only while enabled, resets on
// - fast age uses the short period
// - aggressive back-off bit, default from strap
module sgfc_global_ctrl #(
  parameter int unsigned FAST_AGE_US = `SGFC_FAST_AGE_US,
  parameter int unsigned NORMAL_AGE_US = `SGFC_NORMAL_AGE_S * 1000000,
  parameter int unsigned PORTS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pause_strap_input,
  input wire logic backoff_strap_input,
  input wire logic [PORTS-1:0] link_up,
  input wire logic an_tx_pause,
  input wire logic an_rx_pause,
  input wire logic frm_valid,
  input wire logic [15:0] frm_type_len,
  input wire logic [47:0] frm_dest_addr,
  input wire logic frm_is_pause,
  input wire logic frm_bad,
  input wire logic [11:0] frm_length,
  input wire logic [11:0] frm_data_len,
  output logic frm_done,
  output logic frm_drop,
  output logic tx_fc_en,
  output logic rx_fc_en,
  output logic aggr_backoff_en,
  output logic age_tick,
  output logic fast_pass,
  output logic flush_all
);

  localparam int unsigned US_CYCLES = `SGFC_CLK_MHZ;

  // ----------------------------------------
  // reset release and strap synchronisers
  // ----------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // strap flops run through reset so the pin level is ready at release
  logic pause_s1_q;
  logic pause_s2_q;
  logic back_s1_q;
  logic back_s2_q;

  always_ff @(posedge clk) begin
    pause_s1_q <= pause_strap_input;
    pause_s2_q <= pause_s1_q;
    back_s1_q <= backoff_strap_input;
    back_s2_q <= back_s1_q;
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  function automatic sgfc_pkg::sgfc_sel_t reg_sel(input logic [7:0] addr);
    if (addr == `SGFC_OFS_CTL_ONE) begin
      reg_sel = sgfc_pkg::SGFC_SEL_ONE;
    end else if (addr == `SGFC_OFS_CTL_TWO) begin
      reg_sel = sgfc_pkg::SGFC_SEL_TWO;
    end else begin
      reg_sel = sgfc_pkg::SGFC_SEL_NONE;
    end
  endfunction

  logic [7:0] ctl1_q;
  logic [7:0] ctl1_d;
  logic [7:0] ctl2_q;
  logic [7:0] ctl2_d;
  logic strap_done_q;
  logic strap_done_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    strap_done_d = 1'b1;
    rdata_d = 8'h00;
    // first cycle after release takes the strap levels
    if (!strap_done_q) begin
      ctl1_d[`SGFC_B1_TX_PAUSE_DIS] = pause_s2_q;
      ctl1_d[`SGFC_B1_RX_PAUSE_DIS] = pause_s2_q;
      ctl1_d[`SGFC_B1_AGGR_BACKOFF] = back_s2_q;
    end
    if (reg_wr) begin
      case (reg_sel(reg_addr))
        sgfc_pkg::SGFC_SEL_ONE: begin
          ctl1_d = reg_wdata;
        end
        sgfc_pkg::SGFC_SEL_TWO: begin
          ctl2_d = reg_wdata & `SGFC_CTL_TWO_MASK;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_sel(reg_addr))
        sgfc_pkg::SGFC_SEL_ONE: begin
          rdata_d = ctl1_q;
        end
        sgfc_pkg::SGFC_SEL_TWO: begin
          rdata_d = ctl2_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q <= `SGFC_CTL_ONE_RST;
      ctl2_q <= `SGFC_CTL_TWO_RST;
      strap_done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      strap_done_q <= strap_done_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // microsecond enable
  // ----------------------------------------
  logic [5:0] us_cnt_q;
  logic [5:0] us_cnt_d;
  logic us_tick_q;
  logic us_tick_d;

  always_comb begin
    us_tick_d = 1'b0;
    if (us_cnt_q == 6'(US_CYCLES - 1)) begin
      us_cnt_d = 6'h00;
      us_tick_d = 1'b1;
    end else begin
      us_cnt_d = us_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_q <= 6'h00;
      us_tick_q <= 1'b0;
    end else begin
      us_cnt_q <= us_cnt_d;
      us_tick_q <= us_tick_d;
    end
  end

  // ----------------------------------------
  // link loss detection and mac controls
  // ----------------------------------------
  logic [PORTS-1:0] link_q;
  logic link_lost;
  logic link_trig;
  logic flush_q;
  logic flush_d;
  logic tx_fc_q;
  logic tx_fc_d;
  logic rx_fc_q;
  logic rx_fc_d;
  logic backoff_q;
  logic backoff_d;

  always_comb begin
    link_lost = |(link_q & ~link_up);
    link_trig = link_lost && ctl2_q[`SGFC_B2_LINK_AGE];
    flush_d = link_trig;
    tx_fc_d = an_tx_pause && !ctl1_q[`SGFC_B1_TX_PAUSE_DIS];
    rx_fc_d = an_rx_pause && !ctl1_q[`SGFC_B1_RX_PAUSE_DIS];
    backoff_d = ctl1_q[`SGFC_B1_AGGR_BACKOFF];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= '0;
      flush_q <= 1'b0;
      tx_fc_q <= 1'b0;
      rx_fc_q <= 1'b0;
      backoff_q <= 1'b0;
    end else begin
      link_q <= link_up;
      flush_q <= flush_d;
      tx_fc_q <= tx_fc_d;
      rx_fc_q <= rx_fc_d;
      backoff_q <= backoff_d;
    end
  end

  assign flush_all = flush_q;
  assign tx_fc_en = tx_fc_q;
  assign rx_fc_en = rx_fc_q;
  assign aggr_backoff_en = backoff_q;

  // ----------------------------------------
  // aging timer and frame filter
  // ----------------------------------------
  logic age_tick_w;
  logic pend_w;

  sgfc_age_timer #(
    .FAST_AGE_US(FAST_AGE_US),
    .NORMAL_AGE_US(NORMAL_AGE_US)
  ) u_age (
    .clk(clk),
    .rst_n(rst_n),
    .us_tick(us_tick_q),
    .aging_en(ctl1_q[`SGFC_B1_AGE_EN]),
    .fast_en(ctl1_q[`SGFC_B1_FAST_AGE]),
    .link_trig(link_trig),
    .age_tick_q(age_tick_w),
    .pend_q(pend_w)
  );

  assign age_tick = age_tick_w;
  assign fast_pass = pend_w;

  logic done_w;
  logic drop_w;

  sgfc_frame_filter u_filt (
    .clk(clk),
    .rst_n(rst_n),
    .cfd_sel(ctl2_q[`SGFC_B2_CFD_SEL]),
    .pass_all(ctl1_q[`SGFC_B1_PASS_ALL]),
    .long_en(ctl1_q[`SGFC_B1_LONG_EN]),
    .len_check(ctl1_q[`SGFC_B1_LEN_CHECK]),
    .frm_valid(frm_valid),
    .frm_type_len(frm_type_len),
    .frm_dest_addr(frm_dest_addr),
    .frm_is_pause(frm_is_pause),
    .frm_bad(frm_bad),
    .frm_length(frm_length),
    .frm_data_len(frm_data_len),
    .done_q(done_w),
    .drop_q(drop_w)
  );

  assign frm_done = done_w;
  assign frm_drop = drop_w;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_link_fast_pass: assert property (@(posedge clk) disable iff (!rst_n)
    link_trig |=> fast_pass)
    else $error("link loss did not start a fast pass");

  a_link_flush: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flush_all) |-> $past(ctl2_q[`SGFC_B2_LINK_AGE]) && $past(link_lost))
    else $error("flush without enabled link loss");

  a_tx_pause_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> tx_fc_en == ($past(an_tx_pause) && !$past(ctl1_q[`SGFC_B1_TX_PAUSE_DIS])))
    else $error("tx flow control enable wrong");

  a_rx_pause_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ctl1_q[`SGFC_B1_RX_PAUSE_DIS] |=> !rx_fc_en)
    else $error("rx flow control on while disabled");

  a_pause_strap: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_done_q) && !$past(reg_wr) |-> ctl1_q[`SGFC_B1_TX_PAUSE_DIS] == $past(pause_s2_q)
    && ctl1_q[`SGFC_B1_RX_PAUSE_DIS] == $past(pause_s2_q))
    else $error("pause defaults not taken from strap");

  a_aging_stops: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl1_q[`SGFC_B1_AGE_EN] ##1 !ctl1_q[`SGFC_B1_AGE_EN] |-> !age_tick)
    else $error("age tick while aging disabled");

  a_backoff_strap: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_done_q) && !$past(reg_wr) |-> ##1 aggr_backoff_en == $past(back_s2_q, 2))
    else $error("back-off default not taken from strap");

  a_strap_once: assert property (@(posedge clk) disable iff (!rst_n)
    strap_done_q && reg_wr && reg_addr == `SGFC_OFS_CTL_ONE |=> ctl1_q == $past(reg_wdata))
    else $error("software write to control one lost");

endmodule // sgfc_global_ctrl
`default_nettype wire

// File: sgfc_consts.svh
// constants for the global frame control register bank
// assumes a 50 MHz core clock and byte-wide register access
`ifndef SGFC_CONSTS_SVH
`define SGFC_CONSTS_SVH

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define SGFC_OFS_CTL_TWO 8'h02
`define SGFC_OFS_CTL_ONE 8'h03
`define SGFC_CTL_TWO_MASK 8'h03
`define SGFC_CTL_ONE_RST 8'h04
`define SGFC_CTL_TWO_RST 8'h00
`define SGFC_B2_CFD_SEL 1
`define SGFC_B2_LINK_AGE 0
`define SGFC_B1_PASS_ALL 7
`define SGFC_B1_LONG_EN 6
`define SGFC_B1_TX_PAUSE_DIS 5
`define SGFC_B1_RX_PAUSE_DIS 4
`define SGFC_B1_LEN_CHECK 3
`define SGFC_B1_AGE_EN 2
`define SGFC_B1_FAST_AGE 1
`define SGFC_B1_AGGR_BACKOFF 0

// ----------------------------------------
// frame classification
// ----------------------------------------
`define SGFC_CTRL_TYPE 16'h8808
`define SGFC_CTRL_DA 48'h0180C2000001
`define SGFC_LEN_FIELD_MAX 16'h05DC
`define SGFC_LONG_MAX_LEN 12'h800
`define SGFC_NORMAL_MAX_LEN 12'h600

// ----------------------------------------
// timing
// ----------------------------------------
`define SGFC_CLK_MHZ 50
`define SGFC_FAST_AGE_US 800
`define SGFC_NORMAL_AGE_S 300

`endif

// File: sgfc_pkg.sv
// types shared by the global frame control register bank
// assumes nothing beyond a SystemVerilog compiler
package sgfc_pkg;

  typedef enum logic [1:0] {
    SGFC_SEL_NONE = 2'b00,
    SGFC_SEL_ONE = 2'b01,
    SGFC_SEL_TWO = 2'b10
  } sgfc_sel_t;

endpackage

// File: sgfc_frame_filter.sv
// per-frame drop verdict from the global control bits
// assumes frame descriptors arrive as one-cycle pulses on the core clock
`timescale 1ns/1ps
`default_nettype none
`include "sgfc_consts.svh"

module sgfc_frame_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfd_sel,
  input wire logic pass_all,
  input wire logic long_en,
  input wire logic len_check,
  input wire logic frm_valid,
  input wire logic [15:0] frm_type_len,
  input wire logic [47:0] frm_dest_addr,
  input wire logic frm_is_pause,
  input wire logic frm_bad,
  input wire logic [11:0] frm_length,
  input wire logic [11:0] frm_data_len,
  output logic done_q,
  output logic drop_q
);

  logic done_d;
  logic drop_d;
  logic ctrl_hit;
  logic too_long;
  logic len_err;

  always_comb begin
    if (cfd_sel) begin
      ctrl_hit = (frm_type_len == `SGFC_CTRL_TYPE) || (frm_dest_addr == `SGFC_CTRL_DA);
    end else begin
      ctrl_hit = frm_is_pause;
    end
    too_long = frm_length > (long_en ? `SGFC_LONG_MAX_LEN : `SGFC_NORMAL_MAX_LEN);
    len_err = len_check && (frm_type_len < `SGFC_LEN_FIELD_MAX) &&
              (frm_type_len != {4'h0, frm_data_len});
    done_d = frm_valid;
    drop_d = frm_valid && !pass_all && (ctrl_hit || frm_bad || too_long || len_err);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      done_q <= done_d;
      drop_q <= drop_d;
    end
  end

  a_ctrl_type_drop: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && cfd_sel && !pass_all && frm_type_len == `SGFC_CTRL_TYPE |=> drop_q)
    else $error("control type frame not dropped");

  a_pause_only_drop: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && !cfd_sel && !frm_is_pause && !frm_bad && !too_long && !len_err
    |=> done_q && !drop_q)
    else $error("non-pause frame dropped in pause mode");

  a_pass_all_fwd: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && pass_all |=> done_q && !drop_q)
    else $error("frame dropped while passing all");

  a_long_frame_ok: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && !pass_all && frm_length > `SGFC_NORMAL_MAX_LEN |=> drop_q == !$past(long_en)
    || $past(frm_length) > `SGFC_LONG_MAX_LEN || $past(ctrl_hit) || $past(frm_bad)
    || $past(len_err))
    else $error("long frame verdict wrong");

  a_len_field_drop: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && !pass_all && len_check && frm_type_len < `SGFC_LEN_FIELD_MAX
    && frm_type_len != {4'h0, frm_data_len} |=> drop_q)
    else $error("length mismatch frame not dropped");

endmodule // sgfc_frame_filter
`default_nettype wire

// File: sgfc_age_timer.sv
// address aging period timer with fast and link-change passes
// assumes us_tick is a one-cycle pulse every microsecond
`timescale 1ns/1ps
`default_nettype none
`include "sgfc_consts.svh"

module sgfc_age_timer #(
  parameter int unsigned FAST_AGE_US = `SGFC_FAST_AGE_US,
  parameter int unsigned NORMAL_AGE_US = `SGFC_NORMAL_AGE_S * 1000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic us_tick,
  input wire logic aging_en,
  input wire logic fast_en,
  input wire logic link_trig,
  output logic age_tick_q,
  output logic pend_q
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] lim;
  logic pend_d;
  logic age_tick_d;

  always_comb begin
    cnt_d = cnt_q;
    pend_d = pend_q;
    age_tick_d = 1'b0;
    // a link-change pass ends just short of the fast period
    if (pend_q) begin
      lim = 32'(FAST_AGE_US - 2);
    end else if (fast_en) begin
      lim = 32'(FAST_AGE_US - 1);
    end else begin
      lim = 32'(NORMAL_AGE_US - 1);
    end
    if (link_trig) begin
      pend_d = 1'b1;
      cnt_d = 32'h0;
    end else if (aging_en && us_tick) begin
      if (cnt_q >= lim) begin
        age_tick_d = 1'b1;
        cnt_d = 32'h0;
        pend_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      pend_q <= 1'b0;
      age_tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      age_tick_q <= age_tick_d;
    end
  end

  a_fast_period: assert property (@(posedge clk) disable iff (!rst_n)
    aging_en && us_tick && fast_en && !pend_q && !link_trig
    |=> age_tick_q == ($past(cnt_q) >= 32'(FAST_AGE_US - 1)))
    else $error("fast aging period wrong");

endmodule // sgfc_age_timer
`default_nettype wire

// File: switch_global_frame_control_tb.sv
// self-checking bench for the global frame control register bank
// assumes sgfc_consts.svh on the include path and short aging parameters
`timescale 1ns/1ps
`default_nettype none
`include "sgfc_consts.svh"

`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module switch_global_frame_control_tb;
  localparam int unsigned FAST_US = 4;
  localparam int unsigned NORM_US = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pause_strap_input = 1'b0;
  logic backoff_strap_input = 1'b0;
  logic [3:0] link_up = 4'hF;
  logic an_tx_pause = 1'b0;
  logic an_rx_pause = 1'b0;
  logic frm_valid = 1'b0;
  logic [15:0] frm_type_len = 16'h0000;
  logic [47:0] frm_dest_addr = 48'h000000000000;
  logic frm_is_pause = 1'b0;
  logic frm_bad = 1'b0;
  logic [11:0] frm_length = 12'h000;
  logic [11:0] frm_data_len = 12'h000;
  logic frm_done, frm_drop, tx_fc_en, rx_fc_en, aggr_backoff_en;
  logic age_tick, fast_pass, flush_all;
  int error_cnt = 0;
  int checks_done = 0;
  int ctl1_m, ctl2_m, n, cnt;
  logic [31:0] rng = 32'h51BA;

  always #10 clk = ~clk;

  sgfc_global_ctrl #(.FAST_AGE_US(FAST_US), .NORMAL_AGE_US(NORM_US), .PORTS(4)) u_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pause_strap_input(pause_strap_input),
    .backoff_strap_input(backoff_strap_input), .link_up(link_up), .an_tx_pause(an_tx_pause),
    .an_rx_pause(an_rx_pause), .frm_valid(frm_valid), .frm_type_len(frm_type_len),
    .frm_dest_addr(frm_dest_addr), .frm_is_pause(frm_is_pause), .frm_bad(frm_bad),
    .frm_length(frm_length), .frm_data_len(frm_data_len), .frm_done(frm_done),
    .frm_drop(frm_drop), .tx_fc_en(tx_fc_en), .rx_fc_en(rx_fc_en),
    .aggr_backoff_en(aggr_backoff_en), .age_tick(age_tick), .fast_pass(fast_pass),
    .flush_all(flush_all)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic ps, input logic bs);
    @(posedge clk);
    nrst <= 1'b0;
    pause_strap_input <= ps;
    backoff_strap_input <= bs;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    ctl1_m = 8'h04 | (ps ? 8'h30 : 8'h00) | (bs ? 8'h01 : 8'h00);
    ctl2_m = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `SGFC_OFS_CTL_ONE) ctl1_m = d;
    if (a == `SGFC_OFS_CTL_TWO) ctl2_m = d & 8'h03;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk_regs();
    logic [7:0] d;
    rd(`SGFC_OFS_CTL_ONE, d);
    `TB_CHK(d, ctl1_m[7:0])
    rd(`SGFC_OFS_CTL_TWO, d);
    `TB_CHK(d, ctl2_m[7:0])
  endtask

  task automatic frame(input logic [15:0] t, input logic [47:0] da, input logic p,
                       input logic b, input logic [11:0] len, input logic [11:0] dl);
    int lim;
    int hit;
    int exp_drop;
    lim = ctl1_m[6] ? `SGFC_LONG_MAX_LEN : `SGFC_NORMAL_MAX_LEN;
    hit = ctl2_m[1] ? (t == 16'h8808 || da == 48'h0180C2000001) : p;
    exp_drop = !ctl1_m[7] && (hit || b || len > lim || (ctl1_m[3] && t < 1500 && t != dl));
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_type_len <= t;
    frm_dest_addr <= da;
    frm_is_pause <= p;
    frm_bad <= b;
    frm_length <= len;
    frm_data_len <= dl;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1;
    `TB_CHK({frm_done, frm_drop}, {1'b1, exp_drop[0]})
  endtask

  task automatic wait_tick(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (age_tick !== 1'b1 && k <= lim);
    if (k > lim) begin
      error_cnt++;
      $display("Error t=%0t got=%0h exp=%0h", $time, k, lim);
      results();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [15:0] t;
    do_reset(1'b1, 1'b0);
    chk_regs();
    wr(`SGFC_OFS_CTL_ONE, 8'h14);
    wr(`SGFC_OFS_CTL_TWO, 8'hFF);
    wr(8'h05, 8'hA5);
    chk_regs();
    @(posedge clk);
    #1;
    `TB_CHK(reg_rdata, 8'h00)
    rd(8'h05, d);
    `TB_CHK(d, 8'h00)
    $display("test registers done");

    for (int c = 0; c < 16; c++) begin
      rng = xs(rng);
      wr(`SGFC_OFS_CTL_ONE, {c[3], c[2], rng[5:4], c[1], rng[2:0]});
      wr(`SGFC_OFS_CTL_TWO, {6'h00, c[0], rng[6]});
      an_tx_pause <= rng[11];
      an_rx_pause <= rng[12];
      repeat (2) @(posedge clk);
      #1;
      `TB_CHK(tx_fc_en, rng[11] & !ctl1_m[5])
      `TB_CHK(rx_fc_en, rng[12] & !ctl1_m[4])
      `TB_CHK(aggr_backoff_en, ctl1_m[0])
      chk_regs();
      for (int f = 0; f < 16; f++) begin
        rng = xs(rng);
        case (rng[2:0])
          3'h0, 3'h1: t = 16'h8808;
          3'h2: t = 16'h05DB;
          3'h3: t = 16'h05DC;
          3'h4: t = {4'h0, rng[27:16]};
          default: t = rng[31:16];
        endcase
        frame(t, rng[3] ? 48'h0180C2000001 : {rng, rng[15:0]}, rng[8], &rng[10:9],
              rng[6] ? (rng[5] ? (rng[4] ? 12'h601 : 12'h600) : (rng[4] ? 12'h801 : 12'h800))
                     : {1'b0, rng[26:16]},
              rng[7] ? t[11:0] : rng[27:16]);
      end
    end
    $display("test frames done");

    wr(`SGFC_OFS_CTL_ONE, 8'h04);
    wait_tick(600, n);
    wait_tick(600, n);
    `TB_CHK(n, NORM_US * 50)
    wr(`SGFC_OFS_CTL_ONE, 8'h06);
    wait_tick(600, n);
    wait_tick(600, n);
    `TB_CHK(n, FAST_US * 50)
    wr(`SGFC_OFS_CTL_ONE, 8'h00);
    cnt = 0;
    repeat (1200) begin
      @(posedge clk);
      #1;
      cnt += age_tick;
    end
    `TB_CHK(cnt, 0)
    $display("test aging done");

    wr(`SGFC_OFS_CTL_ONE, 8'h04);
    wr(`SGFC_OFS_CTL_TWO, 8'h01);
    wait_tick(600, n);
    @(posedge clk);
    link_up <= 4'hD;
    @(posedge clk);
    #1;
    `TB_CHK({flush_all, fast_pass}, 2'b11)
    @(posedge clk);
    #1;
    `TB_CHK(flush_all, 1'b0)
    wait_tick(600, n);
    `TB_CHK(n >= (FAST_US - 2) * 50 && n <= (FAST_US - 1) * 50 + 2, 1'b1)
    `TB_CHK(fast_pass, 1'b0)
    wait_tick(600, n);
    `TB_CHK(n, NORM_US * 50)
    link_up <= 4'hF;
    wr(`SGFC_OFS_CTL_TWO, 8'h00);
    link_up <= 4'h7;
    cnt = 0;
    repeat (5) begin
      @(posedge clk);
      #1;
      cnt += flush_all;
    end
    `TB_CHK(cnt, 0)
    $display("test link change done");

    do_reset(1'b0, 1'b1);
    chk_regs();
    @(posedge clk);
    #1;
    `TB_CHK({tx_fc_en, rx_fc_en}, {an_tx_pause, an_rx_pause})
    `TB_CHK(aggr_backoff_en, 1'b1)
    $display("test second reset done");
    results();
  end
endmodule // switch_global_frame_control_tb

`default_nettype wire
